// ### idt_timing_sel.sv
// Behaviour
// R1: Bits 7:6 of the config field name the input clock, 00=50, 01=40, 10=33, 11=25 MHz.
// R2: Each of the 16 basic codes gives a fixed setup, pulse, recovery and cycle count.
// R3: Byte cycles under basic timing use the per-clock pulse, recovery and cycle counts.
// R4: The hidden timing set is not reachable through ordinary drive port accesses.
// R5: The hidden set is exposed only after the unlock sequence has completed.
// R6: Ending programming hides the set again so port accesses reach the drive.
// R7: Writes to drive/head bit 4 in the active range switch timing to the chosen drive.
// R8: Selection bit 7 picks the pair: basic/Timing 0 at 0, Timing 1/Timing 0 at 1.
// R9: Selection bit 2 picks the source for drive 0 and bit 3 for drive 1.
// R10: Primary range decodes with address bit seven at 1 and uses its own selection register.
// R11: Secondary range decodes with address bit seven at 0 and uses its own selection register.
// R12: Only one range is active, chosen by config bit 2: 0 primary, 1 secondary.
// R13: Drive/head bit 0 picks which subset takes pulse/recovery writes while unlocked.
// R14: After reset the set is hidden and basic preset timing is used.
// R15: Each strobe's setup, active and recovery phases last the selected counts exactly.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
module idt_timing_sel
    import idt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             drv_cs,
    output logic             drv_rd_n,
    output logic             drv_wr_n,
    output logic [2:0]       drv_addr,
    output logic [15:0]      drv_wdata,
    output logic             drv_oe,
    input  wire logic [15:0] drv_rdata
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0]  cfg_r,  cfg_nxt;
    logic [7:0]  sel_r  [2];
    logic [7:0]  sel_nxt [2];
    logic [7:0]  rtim_r [2];
    logic [7:0]  rtim_nxt [2];
    logic [7:0]  wtim_r [2];
    logic [7:0]  wtim_nxt [2];
    logic        drive_r,  drive_nxt;
    logic        subset_r, subset_nxt;
    logic        unlock_r, unlock_nxt;
    logic [1:0]  keycnt_r, keycnt_nxt;
    idt_req_t    req_r,    req_nxt;
    idt_state_t  st_r,     st_nxt;
    logic [4:0]  cnt_r,    cnt_nxt;
    logic        rdy_r,    rdy_nxt;
    logic [31:0] rdata_r,  rdata_nxt;
    logic        cs_r,     cs_nxt;
    logic        rdn_r,    rdn_nxt;
    logic        wrn_r,    wrn_nxt;
    logic [2:0]  daddr_r,  daddr_nxt;
    logic [15:0] dwdata_r, dwdata_nxt;
    logic        doe_r,    doe_nxt;
    logic        dwr_r,    dwr_nxt;

    // ****************************************
    // Timing source selection
    // ****************************************
    logic        range;
    logic [7:0]  cur_sel;
    logic        pick;
    idt_src_t    src;
    idt_tim_t    tim16;
    idt_tim_t    tim;
    logic [7:0]  enh_byte;
    logic [6:0]  enh_sum;
    logic        byte_cyc;
    logic        wr_cyc;

    assign range    = cfg_r[CFG_RANGE_BIT];                                      // R12
    assign cur_sel  = sel_r[range];                                              // R10 R11
    assign pick     = drive_r ? cur_sel[SEL_D1_BIT] : cur_sel[SEL_D0_BIT];       // R9
    assign wr_cyc   = (st_r == ST_IDLE) ? req_r.write : dwr_r;
    assign byte_cyc = (st_r == ST_IDLE) ? (req_r.port != PORT_DATA) : (daddr_r != PORT_DATA);

    always_comb begin
        src = SRC_BASIC;
        if (pick) begin
            src = SRC_T0;                                                        // R8
        end else if (cur_sel[SEL_PAIR_BIT]) begin
            src = SRC_T1;                                                        // R8
        end
        tim16 = BASIC_TIM[cfg_r[CFG_BASIC_LSB +: 4]];                            // R2
        enh_byte = wr_cyc ? wtim_r[src == SRC_T1] : rtim_r[src == SRC_T1];
        enh_sum = 7'(ENH_SETUP) + 7'(enh_byte[7:4]) + 7'(ENH_PULSE_ADD)
                + 7'(enh_byte[3:0]) + 7'(ENH_RECOV_ADD);
        if (src == SRC_BASIC) begin
            tim = tim16;
            if (byte_cyc) begin
                tim = BYTE_TIM[cfg_r[CFG_CLK_LSB +: 2]];                         // R1 R3
                tim.setup = tim16.setup;
            end
        end else begin
            tim.setup = ENH_SETUP;
            tim.pulse = 5'(enh_byte[7:4]) + ENH_PULSE_ADD;
            tim.recov = 5'(enh_byte[3:0]) + ENH_RECOV_ADD;
            tim.cycle = (enh_sum > 7'(CYC_SAT)) ? CYC_SAT : enh_sum[4:0];
        end
    end

    // ****************************************
    // Bus decode, registers and strobe sequencer
    // ****************************************
    logic        acc;
    logic [11:0] a;
    logic [2:0]  port;
    logic        io_hit;
    logic        hid;
    idt_kind_t   kind;
    logic [7:0]  wb;

    assign acc  = hsel & htrans[1] & hready;
    assign a    = haddr[11:0];
    assign port = a[4:2];
    // Address bit seven must be 1 for primary and 0 for secondary
    assign io_hit = (a[11:6] == IO_BASE_SEL) & (a[IO_ADDR7_BIT] == ~range);      // R10 R11
    // Hidden ports shadow the drive only while unlocked; 0x6 always reaches the drive
    assign hid  = unlock_r & ((port == PORT_DATA) | (port == PORT_WTIM)
                | (port == PORT_KEY) | (port == PORT_SEL));                      // R4 R5
    assign wb   = hwdata[7:0];

    always_comb begin
        kind = K_NONE;
        if (io_hit) begin
            kind = hid ? K_HID : K_DRV;                                          // R4
        end else if (a == ADDR_CFG) begin
            kind = K_CFG;
        end else if (a == ADDR_STAT) begin
            kind = K_STAT;
        end
    end

    always_comb begin
        cfg_nxt    = cfg_r;
        sel_nxt    = sel_r;
        rtim_nxt   = rtim_r;
        wtim_nxt   = wtim_r;
        drive_nxt  = drive_r;
        subset_nxt = subset_r;
        unlock_nxt = unlock_r;
        keycnt_nxt = keycnt_r;
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        rdy_nxt    = rdy_r;
        rdata_nxt  = rdata_r;
        cs_nxt     = cs_r;
        rdn_nxt    = rdn_r;
        wrn_nxt    = wrn_r;
        daddr_nxt  = daddr_r;
        dwdata_nxt = dwdata_r;
        doe_nxt    = doe_r;
        dwr_nxt    = dwr_r;
        req_nxt    = '0;

        // Data phase of any write access, including stalled drive writes
        if (req_r.valid && req_r.write) begin
            case (req_r.kind)
                K_CFG: begin
                    cfg_nxt = wb & CFG_WMASK;
                end
                K_HID: begin
                    case (req_r.port)
                        PORT_DATA: rtim_nxt[subset_r] = wb;                      // R13
                        PORT_WTIM: wtim_nxt[subset_r] = wb;                      // R13
                        PORT_SEL:  sel_nxt[range] = wb;                          // R10 R11
                        PORT_KEY: begin
                            if (wb == RELOCK_KEY) begin
                                unlock_nxt = 1'b0;                               // R6
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                K_DRV: begin
                    if (req_r.port == PORT_DRVHD) begin
                        drive_nxt  = wb[DH_DRIVE_BIT];                           // R7
                        subset_nxt = wb[DH_SUBSET_BIT];                          // R13
                    end
                    if (req_r.port == PORT_KEY && wb == UNLOCK_KEY) begin
                        keycnt_nxt = keycnt_r + 2'h1;                            // R5
                        if (keycnt_r + 2'h1 == KEY_COUNT) begin
                            unlock_nxt = 1'b1;                                   // R5
                            keycnt_nxt = 2'h0;
                        end
                    end else begin
                        keycnt_nxt = 2'h0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Strobe sequencer; counts load as count minus one
        case (st_r)
            ST_IDLE: begin
                if (req_r.valid && req_r.kind == K_DRV) begin
                    st_nxt     = ST_SETUP;
                    cnt_nxt    = tim.setup - 5'h01;                              // R15
                    cs_nxt     = 1'b1;
                    daddr_nxt  = req_r.port;
                    dwr_nxt    = req_r.write;
                    dwdata_nxt = hwdata[15:0];
                    doe_nxt    = req_r.write;
                end
            end
            ST_SETUP: begin
                cnt_nxt = cnt_r - 5'h01;
                if (cnt_r == 5'h00) begin
                    st_nxt  = ST_PULSE;
                    cnt_nxt = tim.pulse - 5'h01;                                 // R15
                    rdn_nxt = dwr_r;
                    wrn_nxt = ~dwr_r;
                end
            end
            ST_PULSE: begin
                cnt_nxt = cnt_r - 5'h01;
                if (cnt_r == 5'h00) begin
                    st_nxt  = ST_RECOV;
                    cnt_nxt = tim.recov - 5'h01;                                 // R15
                    rdn_nxt = 1'b1;
                    wrn_nxt = 1'b1;
                    cs_nxt  = 1'b0;
                    doe_nxt = 1'b0;
                    if (!dwr_r) begin
                        rdata_nxt = {16'h0000, drv_rdata};
                    end
                end
            end
            ST_RECOV: begin
                cnt_nxt = cnt_r - 5'h01;
                if (cnt_r == 5'h00) begin
                    st_nxt  = ST_IDLE;
                    rdy_nxt = 1'b1;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase

        // Address phase; drive accesses stall the bus until recovery ends
        if (acc) begin
            req_nxt = '{valid: 1'b1, write: hwrite, kind: kind, port: port};
            rdata_nxt = 32'h0000_0000;
            case (kind)
                K_CFG:  rdata_nxt[7:0] = cfg_r;
                K_STAT: begin
                    rdata_nxt[STAT_CYC_LSB +: 5] = tim.cycle;
                    rdata_nxt[STAT_SRC_LSB +: 2] = src;
                    rdata_nxt[STAT_BUSY_BIT]     = (st_r != ST_IDLE);
                    rdata_nxt[STAT_DRV_BIT]      = drive_r;
                    rdata_nxt[STAT_UNL_BIT]      = unlock_r;
                end
                K_HID: begin
                    case (port)
                        PORT_DATA: rdata_nxt[7:0] = rtim_r[subset_r];
                        PORT_WTIM: rdata_nxt[7:0] = wtim_r[subset_r];
                        PORT_SEL:  rdata_nxt[7:0] = sel_r[range];
                        default:   rdata_nxt[7:0] = 8'h00;
                    endcase
                end
                K_DRV:  rdy_nxt = 1'b0;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r    <= CFG_RESET;                                               // R14
            for (int i = 0; i < 2; i++) begin
                sel_r[i]  <= SEL_RESET;                                          // R14
                rtim_r[i] <= TIM_RESET;
                wtim_r[i] <= TIM_RESET;
            end
            drive_r  <= 1'b0;
            subset_r <= 1'b0;
            unlock_r <= 1'b0;                                                    // R14
            keycnt_r <= 2'h0;
            req_r    <= '0;
            st_r     <= ST_IDLE;
            cnt_r    <= 5'h00;
            rdy_r    <= 1'b1;
            rdata_r  <= 32'h0000_0000;
            cs_r     <= 1'b0;
            rdn_r    <= 1'b1;
            wrn_r    <= 1'b1;
            daddr_r  <= 3'h0;
            dwdata_r <= 16'h0000;
            doe_r    <= 1'b0;
            dwr_r    <= 1'b0;
            hresp    <= 1'b0;
        end else begin
            cfg_r    <= cfg_nxt;
            sel_r    <= sel_nxt;
            rtim_r   <= rtim_nxt;
            wtim_r   <= wtim_nxt;
            drive_r  <= drive_nxt;
            subset_r <= subset_nxt;
            unlock_r <= unlock_nxt;
            keycnt_r <= keycnt_nxt;
            req_r    <= req_nxt;
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            rdy_r    <= rdy_nxt;
            rdata_r  <= rdata_nxt;
            cs_r     <= cs_nxt;
            rdn_r    <= rdn_nxt;
            wrn_r    <= wrn_nxt;
            daddr_r  <= daddr_nxt;
            dwdata_r <= dwdata_nxt;
            doe_r    <= doe_nxt;
            dwr_r    <= dwr_nxt;
            hresp    <= 1'b0;
        end
    end

    assign hreadyout = rdy_r;
    assign hrdata    = rdata_r;
    assign drv_cs    = cs_r;
    assign drv_rd_n  = rdn_r;
    assign drv_wr_n  = wrn_r;
    assign drv_addr  = daddr_r;
    assign drv_wdata = dwdata_r;
    assign drv_oe    = doe_r;

endmodule

// ### idt_pkg.sv
package idt_pkg;

    // ****************************************
    // Timing records and states
    // ****************************************
    typedef struct packed {
        logic [4:0] setup;
        logic [4:0] pulse;
        logic [4:0] recov;
        logic [4:0] cycle;
    } idt_tim_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SETUP = 2'b01,
        ST_PULSE = 2'b10,
        ST_RECOV = 2'b11
    } idt_state_t;

    typedef enum logic [1:0] {
        SRC_BASIC = 2'b00,
        SRC_T0    = 2'b01,
        SRC_T1    = 2'b10
    } idt_src_t;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_CFG  = 3'b001,
        K_STAT = 3'b010,
        K_HID  = 3'b011,
        K_DRV  = 3'b100
    } idt_kind_t;

    typedef struct packed {
        logic      valid;
        logic      write;
        idt_kind_t kind;
        logic [2:0] port;
    } idt_req_t;

    // ****************************************
    // Bus map
    // ****************************************
    localparam logic [11:0] ADDR_CFG    = 12'h000;
    localparam logic [11:0] ADDR_STAT   = 12'h004;
    localparam logic [5:0]  IO_BASE_SEL = 6'h01;
    localparam int          IO_ADDR7_BIT = 5;

    // ****************************************
    // Fields and reset values
    // ****************************************
    localparam int          CFG_BASIC_LSB = 4;
    localparam int          CFG_CLK_LSB   = 6;
    localparam int          CFG_RANGE_BIT = 2;
    localparam logic [7:0]  CFG_WMASK     = 8'hFE;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    localparam logic [7:0]  TIM_RESET     = 8'h00;
    localparam logic [7:0]  SEL_RESET     = 8'h00;
    localparam int          SEL_PAIR_BIT  = 7;
    localparam int          SEL_D0_BIT    = 2;
    localparam int          SEL_D1_BIT    = 3;
    localparam int          DH_DRIVE_BIT  = 4;
    localparam int          DH_SUBSET_BIT = 0;
    localparam int          STAT_CYC_LSB  = 8;
    localparam int          STAT_SRC_LSB  = 4;
    localparam int          STAT_BUSY_BIT = 2;
    localparam int          STAT_DRV_BIT  = 1;
    localparam int          STAT_UNL_BIT  = 0;

    localparam logic [2:0]  PORT_DATA  = 3'h0;
    localparam logic [2:0]  PORT_WTIM  = 3'h1;
    localparam logic [2:0]  PORT_KEY   = 3'h2;
    localparam logic [2:0]  PORT_SEL   = 3'h3;
    localparam logic [2:0]  PORT_DRVHD = 3'h6;
    localparam logic [7:0]  UNLOCK_KEY = 8'hA5;
    localparam logic [7:0]  RELOCK_KEY = 8'h5A;
    localparam logic [1:0]  KEY_COUNT  = 2'h2;

    localparam logic [1:0]  CLK_50 = 2'b00;
    localparam logic [1:0]  CLK_40 = 2'b01;
    localparam logic [1:0]  CLK_33 = 2'b10;
    localparam logic [1:0]  CLK_25 = 2'b11;

    localparam logic [4:0]  ENH_SETUP     = 5'h01;
    localparam logic [4:0]  ENH_PULSE_ADD = 5'h01;
    localparam logic [4:0]  ENH_RECOV_ADD = 5'h02;
    localparam logic [4:0]  CYC_SAT       = 5'h1F;

    // ****************************************
    // Preset timings
    // ****************************************
    localparam idt_tim_t BASIC_TIM [16] = '{
        '{5'h04, 5'h09, 5'h11, 5'h1E}, '{5'h03, 5'h07, 5'h0A, 5'h14},
        '{5'h02, 5'h06, 5'h04, 5'h0C}, '{5'h02, 5'h05, 5'h02, 5'h09},
        '{5'h03, 5'h07, 5'h0E, 5'h18}, '{5'h03, 5'h06, 5'h07, 5'h10},
        '{5'h02, 5'h05, 5'h03, 5'h0A}, '{5'h02, 5'h04, 5'h02, 5'h08},
        '{5'h03, 5'h06, 5'h0B, 5'h14}, '{5'h02, 5'h05, 5'h06, 5'h0D},
        '{5'h02, 5'h04, 5'h02, 5'h08}, '{5'h01, 5'h03, 5'h02, 5'h06},
        '{5'h02, 5'h05, 5'h08, 5'h0F}, '{5'h02, 5'h04, 5'h04, 5'h0A},
        '{5'h01, 5'h03, 5'h02, 5'h06}, '{5'h01, 5'h02, 5'h02, 5'h05}
    };
    // Setup of byte cycles follows the selected code; only the rest differs
    localparam idt_tim_t BYTE_TIM [4] = '{
        '{5'h00, 5'h0F, 5'h0E, 5'h1F}, '{5'h00, 5'h0C, 5'h0B, 5'h19},
        '{5'h00, 5'h0A, 5'h09, 5'h14}, '{5'h00, 5'h08, 5'h06, 5'h0F}
    };

endpackage

// ### idt_timing_sel_properties.sv
module idt_timing_sel_properties
    import idt_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        drv_cs,
    input wire logic        drv_rd_n,
    input wire logic        drv_wr_n,
    input wire logic [2:0]  drv_addr,
    input wire logic        drv_oe
);
    logic       acc;
    logic [3:0] io_a;
    logic       cfgw_r;
    logic       cfgw_nxt;
    logic       rng_r;
    logic       rng_nxt;
    assign acc  = hsel && htrans[1] && hready;
    assign io_a = haddr[5:2];

    // ****************************************
    // Range shadow
    // ****************************************
    // Only the bus is visible here, so the range bit is caught from config writes
    always_comb begin
        cfgw_nxt = cfgw_r;
        rng_nxt  = rng_r;
        if (hready) begin
            cfgw_nxt = acc && hwrite && (haddr[11:0] == ADDR_CFG);
            if (cfgw_r) begin
                rng_nxt = hwdata[CFG_RANGE_BIT];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfgw_r <= 1'b0;
            rng_r  <= 1'b0;
        end else begin
            cfgw_r <= cfgw_nxt;
            rng_r  <= rng_nxt;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_recov;
        !drv_cs ##1 (!drv_cs && !hreadyout);
    endsequence

    a_strobe_excl: assert property (!(!drv_rd_n && !drv_wr_n))
        else $error("both strobes active");
    a_strobe_in_cs: assert property ((!drv_rd_n || !drv_wr_n) |-> drv_cs && !hreadyout)
        else $error("strobe outside a stalled select");
    a_setup_first: assert property ($rose(drv_cs) |-> drv_rd_n && drv_wr_n && !hreadyout)
        else $error("no setup before strobe");
    a_pulse_len: assert property ($fell(drv_rd_n) |-> ##[1:16] drv_rd_n)
        else $error("read pulse length out of range");
    a_recov_min: assert property ($fell(drv_cs) |-> s_recov)
        else $error("recovery too short");
    a_oe_write: assert property (!drv_wr_n |-> drv_oe)
        else $error("write strobe without data drive");
    a_wait_bound: assert property ($fell(hreadyout) |-> !hreadyout [*4] ##[1:36] hreadyout)
        else $error("wait state count out of range");
    a_range_decode: assert property (acc && haddr[11:6] == IO_BASE_SEL
        && haddr[IO_ADDR7_BIT] == rng_r |=> hreadyout && !drv_cs)
        else $error("inactive range reached the drive");
    a_drv_port: assert property ($rose(drv_cs) |-> $past(io_a, 2) == {~rng_r, drv_addr})
        else $error("drive port differs from address");
    a_cs_wait: assert property (drv_cs |-> !hreadyout)
        else $error("bus released during drive cycle");
endmodule

bind idt_timing_sel idt_timing_sel_properties idt_timing_sel_properties_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .drv_cs    (drv_cs),
    .drv_rd_n  (drv_rd_n),
    .drv_wr_n  (drv_wr_n),
    .drv_addr  (drv_addr),
    .drv_oe    (drv_oe)
);

// ### idt_drive_model.sv
module idt_drive_model (
    input  wire logic        drv_cs,
    input  wire logic        drv_rd_n,
    input  wire logic        drv_wr_n,
    input  wire logic [2:0]  drv_addr,
    input  wire logic [15:0] drv_wdata,
    input  wire logic        drv_oe,
    output logic      [15:0] drv_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] regs [8];
    logic [15:0] last;
    // Each port starts with its own number, so a wrong port shows up
    initial begin
        for (int i = 0; i < 8; i++) regs[i] = 16'h1230 + 16'(i);
        last = 16'h0;
    end
    // Data is taken while the strobe is low, whenever the device settles it
    always @(negedge drv_wr_n or drv_wdata) begin
        if (drv_wr_n === 1'b0 && drv_oe === 1'b1) regs[drv_addr] = drv_wdata;
    end
    always @(negedge drv_rd_n) last = regs[drv_addr];
    // Released bus shows the inverse of the last word, never a stale copy
    assign drv_rdata = (drv_cs === 1'b1 && drv_rd_n === 1'b0) ? regs[drv_addr] : ~last;
endmodule

// ### test_ide_drive_timing_select.sv
module test_ide_drive_timing_select
    import idt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        drv_cs, drv_rd_n, drv_wr_n, drv_oe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, drv_addr;
    logic [15:0] drv_wdata, drv_rdata;
    int          n_fail, n_tests, sc, pc, wc, cyc;

    idt_timing_sel idt_timing_sel_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .drv_cs(drv_cs), .drv_rd_n(drv_rd_n), .drv_wr_n(drv_wr_n), .drv_addr(drv_addr),
        .drv_wdata(drv_wdata), .drv_oe(drv_oe), .drv_rdata(drv_rdata));
    idt_drive_model idt_drive_model_i (.drv_cs(drv_cs), .drv_rd_n(drv_rd_n),
        .drv_wr_n(drv_wr_n), .drv_addr(drv_addr), .drv_wdata(drv_wdata), .drv_oe(drv_oe),
        .drv_rdata(drv_rdata));

    // ****************************************
    // Clock, phase counters, timeout
    // ****************************************
    always #2 hclk = ~hclk;
    // Sampled mid-cycle so the counts never race the design's flops
    always @(negedge hclk) begin
        if (drv_cs && drv_rd_n && drv_wr_n) sc++;
        if (!drv_rd_n || !drv_wr_n) pc++;
        if (!hreadyout) wc++;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            finish_test();
        end
    end

    // ****************************************
    // Bus and checking tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdy();
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= {20'h0, a};
        hwrite <= w;
        rdy();
        htrans <= 2'b00;
        hwdata <= d;
        sc = 0;
        pc = 0;
        wc = 0;
        rdy();
    endtask
    task automatic tchk(input int s, input int p, input int r);
        chk(sc, s);
        chk(pc, p);
        // One idle data-phase cycle precedes setup
        chk(wc, s + p + r + 1);
    endtask
    task automatic unl();
        bus(1'b1, 12'h068, 32'(UNLOCK_KEY));
        bus(1'b1, 12'h068, 32'(UNLOCK_KEY));
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        bus(1'b0, ADDR_CFG, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_1E00);
        chk(32'(hresp), 32'h0);
        $display("test reset done");
    endtask
    task automatic t_basic();
        for (int c = 0; c < 16; c++) begin
            bus(1'b1, ADDR_CFG, 32'(c << CFG_BASIC_LSB));
            bus(1'b0, 12'h060, 32'h0);
            chk(rd[15:0], 16'h1230);
            tchk(BASIC_TIM[c].setup, BASIC_TIM[c].pulse, BASIC_TIM[c].recov);
            bus(1'b0, ADDR_STAT, 32'h0);
            chk(rd[12:8], BASIC_TIM[c].cycle);
        end
        $display("test basic done");
    endtask
    task automatic t_byte();
        for (int g = 0; g < 4; g++) begin
            bus(1'b1, ADDR_CFG, 32'(g << CFG_CLK_LSB));
            bus(1'b0, 12'h07C, 32'h0);
            tchk(BASIC_TIM[g * 4].setup, BYTE_TIM[g].pulse, BYTE_TIM[g].recov);
        end
        $display("test byte done");
    endtask
    task automatic t_enh();
        bus(1'b1, ADDR_CFG, 32'hF0);
        bus(1'b1, 12'h068, 32'(UNLOCK_KEY));
        bus(1'b1, 12'h07C, 32'h0);
        bus(1'b1, 12'h068, 32'(UNLOCK_KEY));
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd[0], 1'b0);
        bus(1'b1, 12'h068, 32'(UNLOCK_KEY));
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd[0], 1'b1);
        bus(1'b1, 12'h078, 32'h0);
        bus(1'b1, 12'h060, 32'h31);
        chk(wc, 32'h0);
        bus(1'b1, 12'h078, 32'h1);
        bus(1'b1, 12'h060, 32'h52);
        bus(1'b1, 12'h06C, 32'h8);
        bus(1'b0, 12'h06C, 32'h0);
        chk(rd[7:0], 8'h08);
        bus(1'b1, 12'h068, 32'(RELOCK_KEY));
        bus(1'b0, 12'h060, 32'h0);
        chk(rd[15:0], 16'h1230);
        tchk(1, 2, 2);
        bus(1'b1, 12'h078, 32'h10);
        bus(1'b0, 12'h060, 32'h0);
        tchk(1, 4, 3);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd[5:0], {SRC_T0, 4'h2});
        unl();
        bus(1'b1, 12'h06C, 32'h80);
        bus(1'b1, 12'h068, 32'(RELOCK_KEY));
        bus(1'b1, 12'h078, 32'h0);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd[12:4], {5'h0B, 2'h0, SRC_T1});
        bus(1'b0, 12'h060, 32'h0);
        tchk(1, 6, 4);
        bus(1'b0, 12'h068, 32'h0);
        chk(rd[15:0], 16'h00A5);
        $display("test enhanced done");
    endtask
    task automatic t_range();
        bus(1'b1, ADDR_CFG, 32'hF4);
        bus(1'b0, 12'h060, 32'h0);
        chk(rd, 32'h0);
        chk(wc, 32'h0);
        bus(1'b0, 12'h040, 32'h0);
        chk(rd[15:0], 16'h1230);
        tchk(1, 2, 2);
        bus(1'b1, 12'h058, 32'h10);
        bus(1'b0, ADDR_STAT, 32'h0);
        chk(rd[5:1], {SRC_BASIC, 3'h1});
        $display("test range done");
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        hclk    = 1'b0;
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'b00;
        hwrite  = 1'b0;
        hsize   = 3'b010;
        hwdata  = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        hsel    <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_basic();
        t_byte();
        t_enh();
        t_range();
        finish_test();
    end
endmodule
